// *** hw/pcl_top.sv ***
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ps
// What this block does
// - Standby when pin differs from invert bit
// - Release host reset at configured power-up slot
// - Hold reset released in system-on, assert on shutdown
// - Irq low while unmasked latch set; W1C
// - Test bit pulses irq 100 us, self-clears
// - Cascade falling edge latches; live level visible
// - Watchdog input ignored until host reset released
// - Edge select: 0 falling, 1 rising
// - 10 us debounce before accepting watchdog edge
// - Mode bit picks hard or soft watchdog reset
// - Standby watchdog only with sleep-active bit set
// - Early warning on listed fault shutdown causes
// - Lead time from 2-bit field
// - Warning sets irq; low in off modes
// - GPO mode: pin follows run/sleep level bits
// - GPO levels load 1 if sequenced, else 0
// - Good mode: AND of selected enabled monitors
// - OV/UV latches sticky irq only; pin not pulled low
// - Pin low until reset release, then check
// - Regulator two code from pin, run, sleep
// - Read-only pin level bits; fuse defaults
module pcl_top
	import pcl_pkg::*;
#(
	parameter int unsigned N_REG  = 11,
	parameter int unsigned EW1_CYC = EW_T1_CYC,
	parameter int unsigned EW2_CYC = EW_T2_CYC,
	parameter int unsigned EW3_CYC = EW_T3_CYC
) (
	input  wire logic             CLK_SYS_IN,
	input  wire logic             RESETN_IN,
	input  wire logic             PSEL_IN,
	input  wire logic             PENABLE_IN,
	input  wire logic             PWRITE_IN,
	input  wire logic [11:0]      PADDR_IN,
	input  wire logic [31:0]      PWDATA_IN,
	output logic      [31:0]      PRDATA_OUT,
	output logic                  PREADY_OUT,
	output logic                  PSLVERR_OUT,
	input  wire logic             MODE_OFF_IN,
	input  wire logic             MODE_PWRUP_IN,
	input  wire logic             MODE_SYSON_IN,
	input  wire logic [7:0]       PWRUP_SLOT_IN,
	input  wire logic             PWRDN_RESET_SLOT_IN,
	input  wire logic             FAULT_TIMER_IN,
	input  wire logic             FAULT_CNT_MAX_IN,
	input  wire logic             THERMAL_SD_IN,
	input  wire logic             VIN_OVLO_IN,
	input  wire logic [N_REG-1:0] REG_GOOD_IN,
	input  wire logic [N_REG-1:0] REG_ENABLED_IN,
	input  wire logic [N_REG-1:0] REG_OV_IN,
	input  wire logic [N_REG-1:0] REG_UV_IN,
	input  wire logic             STANDBY_IN,
	input  wire logic             CASCADE_IRQ_IN_N,
	input  wire logic             WDOG_IN,
	input  wire logic             REG_TWO_VOLT_SEL_PIN_IN,
	input  wire logic             REG_TWO_ENABLE_PIN_IN,
	output logic                  STANDBY_STATE_OUT,
	output logic                  HOST_RESET_N_OUT,
	output logic                  HOST_RESET_N_OE_OUT,
	output logic                  HOST_RESET_FREE_OUT,
	output logic                  IRQ_N_OUT,
	output logic                  IRQ_N_OE_OUT,
	output logic                  WDOG_EVENT_OUT,
	output logic                  WDOG_HARD_OUT,
	output logic                  EARLY_WARN_OUT,
	output logic                  POWER_DOWN_GO_OUT,
	output logic                  POWER_GOOD_OUT,
	output logic                  POWER_GOOD_OE_OUT,
	output logic                  PG_FAULT_OUT,
	output logic      [3:0]       REG_TWO_CODE_OUT,
	output logic                  REG_TWO_EN_OUT
);

	// Elaboration check on regulator count and 21-bit lead counter
	if (N_REG < 1 || N_REG > 32 || EW1_CYC < 1 || EW2_CYC < 1 ||
		EW3_CYC < 1 || EW1_CYC > 2**21 || EW2_CYC > 2**21 ||
		EW3_CYC > 2**21) begin : g_bad_n
		$error("N_REG or lead time parameter out of range");
	end

	////////////////////////////////////////////////////////////////////
	// Reset release and APB slave

	logic rst_meta_r;        // First stage, read only by second
	logic rst_n;             // Synchronised reset
	logic pcl_rst_n_r;

	// Asynchronous assert, synchronous release
	always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			rst_meta_r  <= 1'b0;
			pcl_rst_n_r <= 1'b0;
		end else begin
			rst_meta_r  <= 1'b1;
			pcl_rst_n_r <= rst_meta_r;
		end
	end
	assign rst_n = pcl_rst_n_r;

	pcl_ctrl_t         ctrl_r;           // Control bits
	pcl_cfg_t          cfg_r;            // Fuse image
	logic [7:0]        codes_r;          // Sleep code, run code
	logic [N_REG-1:0]  pg_sel_r;         // Good monitor select
	logic [IRQ_W-1:0]  irq_r;            // Sticky latches
	logic [IRQ_W-1:0]  mask_r;           // 1 masks
	logic [31:0]       prdata_r;
	logic              pslverr_r;
	logic [31:0]       rd_mux;
	logic [31:0]       status_w;
	logic              hit;

	// Decode
	wire setup   = PSEL_IN & ~PENABLE_IN;
	wire access  = PSEL_IN & PENABLE_IN;
	wire wr      = access & PWRITE_IN;
	wire hit_ctl = (PADDR_IN == OFS_CTRL);
	wire hit_cfg = (PADDR_IN == OFS_CFG);
	wire hit_cod = (PADDR_IN == OFS_CODES);
	wire hit_sel = (PADDR_IN == OFS_PG_SEL);
	wire hit_irq = (PADDR_IN == OFS_IRQ);
	wire hit_msk = (PADDR_IN == OFS_MASK);
	wire hit_sta = (PADDR_IN == OFS_STAT);
	assign hit = hit_ctl | hit_cfg | hit_cod | hit_sel | hit_irq |
		hit_msk | hit_sta;

	// Read selection; unmapped reads zero with error
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (1'b1)
			hit_ctl: rd_mux[9:0] = ctrl_r;
			hit_cfg: rd_mux[22:0] = cfg_r;
			hit_cod: rd_mux[7:0] = codes_r;
			hit_sel: rd_mux[N_REG-1:0] = pg_sel_r;
			hit_irq: rd_mux[IRQ_W-1:0] = irq_r;
			hit_msk: rd_mux[IRQ_W-1:0] = mask_r;
			hit_sta: rd_mux = status_w;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Read data captured in setup, so access phase has no wait state
	always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
		if (!rst_n) begin
			prdata_r  <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else if (setup) begin
			prdata_r  <= PWRITE_IN ? 32'h0000_0000 : rd_mux;
			pslverr_r <= ~hit;
		end
	end
	assign PRDATA_OUT  = prdata_r;
	assign PREADY_OUT  = access;
	assign PSLVERR_OUT = access & pslverr_r;

	////////////////////////////////////////////////////////////////////
	// Standby and host reset

	pcl_rst_st_t rst_st_r;
	pcl_rst_st_t rst_st_nxt;
	wire standby  = STANDBY_IN ^ ctrl_r.standby_polarity_invert;
	wire sys_run  = MODE_SYSON_IN & ~standby;
	wire sys_slp  = MODE_SYSON_IN & standby;
	wire released = (rst_st_r == RST_FREE);
	wire rel_pt   = MODE_PWRUP_IN & ~MODE_OFF_IN &
		(PWRUP_SLOT_IN == cfg_r.host_reset_release_slot);
	assign STANDBY_STATE_OUT = sys_slp;

	// Release at slot, reassert on off or power-down
	always_comb begin
		rst_st_nxt = rst_st_r;
		case (rst_st_r)
			RST_HELD: if (rel_pt) begin
				rst_st_nxt = RST_FREE;
			end
			RST_FREE: if (MODE_OFF_IN | PWRDN_RESET_SLOT_IN) begin
				rst_st_nxt = RST_HELD;
			end
			default: rst_st_nxt = RST_HELD;
		endcase
	end
	always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
		if (!rst_n) rst_st_r <= RST_HELD;
		else rst_st_r <= rst_st_nxt;
	end
	assign HOST_RESET_N_OUT    = 1'b0;
	assign HOST_RESET_N_OE_OUT = ~released;
	assign HOST_RESET_FREE_OUT = released;

	////////////////////////////////////////////////////////////////////
	// Watchdog input: debounce, edge, gating

	logic [15:0] wd_cnt_r;
	logic        wd_flt_r;       // Debounced level
	logic        wd_ev_r;
	logic        wd_hard_r;
	wire wd_diff = (WDOG_IN != wd_flt_r);
	wire wd_done = wd_diff & (wd_cnt_r == 16'(DBNC_CYC - 1));
	// Edge accepted only after stable level
	wire wd_edge = wd_done &
		(WDOG_IN == cfg_r.wdog_in_edge_sel);
	// Gated off until reset release, sleep needs enable
	wire wd_mon = released & MODE_SYSON_IN &
		(~standby | ctrl_r.wdog_in_sleep_active);

	// Counter restarts whenever the pin bounces back
	always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
		if (!rst_n) begin
			wd_cnt_r  <= 16'h0000;
			wd_flt_r  <= 1'b0;
			wd_ev_r   <= 1'b0;
			wd_hard_r <= 1'b0;
		end else begin
			wd_cnt_r  <= (wd_diff & ~wd_done) ? wd_cnt_r + 16'h0001
				: 16'h0000;
			if (wd_done) wd_flt_r <= WDOG_IN;
			wd_ev_r   <= wd_edge & wd_mon;
			wd_hard_r <= wd_edge & wd_mon &
				cfg_r.wdog_in_hard_sel;
		end
	end
	assign WDOG_EVENT_OUT = wd_ev_r;
	assign WDOG_HARD_OUT  = wd_hard_r;

	////////////////////////////////////////////////////////////////////
	// Early warning

	pcl_ew_st_t  ew_st_r;
	pcl_ew_st_t  ew_st_nxt;
	logic [20:0] ew_cnt_r;
	logic [20:0] ew_lim;
	logic        ew_go_r;
	wire ew_cause = FAULT_TIMER_IN | FAULT_CNT_MAX_IN | THERMAL_SD_IN |
		(VIN_OVLO_IN & ctrl_r.input_overvolt_shutdown_en);
	wire ew_end = (ew_st_r == EW_LEAD) & (ew_cnt_r == ew_lim);

	// Lead time selection
	always_comb begin
		case (cfg_r.early_warn_lead_time)
			2'b00:   ew_lim = 21'(EW_T0_CYC - 1);
			2'b01:   ew_lim = 21'(EW1_CYC - 1);
			2'b10:   ew_lim = 21'(EW2_CYC - 1);
			default: ew_lim = 21'(EW3_CYC - 1);
		endcase
	end

	// Off modes force idle, so the pin stays low
	always_comb begin
		ew_st_nxt = ew_st_r;
		case (ew_st_r)
			EW_IDLE: if (~MODE_OFF_IN & ew_cause) ew_st_nxt = EW_LEAD;
			EW_LEAD: if (ew_end) ew_st_nxt = EW_DONE;
			EW_DONE: ew_st_nxt = EW_DONE;
			default: ew_st_nxt = EW_IDLE;
		endcase
		if (MODE_OFF_IN) ew_st_nxt = EW_IDLE;
	end
	always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
		if (!rst_n) begin
			ew_st_r  <= EW_IDLE;
			ew_cnt_r <= 21'h00_0000;
			ew_go_r  <= 1'b0;
		end else begin
			ew_st_r  <= ew_st_nxt;
			ew_cnt_r <= (ew_st_r == EW_LEAD) ? ew_cnt_r + 21'h00_0001
				: 21'h00_0000;
			ew_go_r  <= ew_end & ~MODE_OFF_IN;
		end
	end
	assign EARLY_WARN_OUT    = (ew_st_r != EW_IDLE);
	assign POWER_DOWN_GO_OUT = ew_go_r;

	////////////////////////////////////////////////////////////////////
	// Power good pin

	logic             pg_hi_r;    // Pin released high
	logic             pg_flt_r;
	logic [N_REG-1:0] pg_part;
	// Disabled regulators drop out of the AND
	assign pg_part = pg_sel_r & REG_ENABLED_IN;
	wire pg_all   = &(REG_GOOD_IN | ~pg_part);
	wire ov_hit   = released & |(REG_OV_IN & pg_part);
	wire uv_hit   = released & |(REG_UV_IN & pg_part);
	wire gpo_lvl  = sys_run ? ctrl_r.pg_pin_run_level :
		sys_slp & ctrl_r.pg_pin_sleep_level;
	// Monitors masked until host reset release
	wire pg_mon   = released & pg_all;
	always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
		if (!rst_n) begin
			pg_hi_r  <= 1'b0;
			pg_flt_r <= 1'b0;
		end else begin
			pg_hi_r  <= cfg_r.power_good_mode_sel ? pg_mon : gpo_lvl;
			pg_flt_r <= cfg_r.power_good_mode_sel & rel_pt &
				(rst_st_r == RST_HELD) & ~pg_all;
		end
	end
	assign POWER_GOOD_OUT    = 1'b0;
	assign POWER_GOOD_OE_OUT = ~pg_hi_r;
	assign PG_FAULT_OUT      = pg_flt_r;

	////////////////////////////////////////////////////////////////////
	// Regulator two

	// Sleep code overrides pin select
	assign REG_TWO_CODE_OUT = standby ? codes_r[7:4] :
		~ctrl_r.reg_two_volt_pin_en ? codes_r[3:0] :
		REG_TWO_VOLT_SEL_PIN_IN ? CODE_1V8 : CODE_3V3;
	wire r2_on = standby ? ctrl_r.reg_two_sleep_on : ctrl_r.reg_two_run_on;
	assign REG_TWO_EN_OUT = r2_on & (~ctrl_r.reg_two_pin_control_en |
		REG_TWO_ENABLE_PIN_IN);

	////////////////////////////////////////////////////////////////////
	// Interrupt latches, test pulse, register writes

	logic             casc_prev_r;
	logic [11:0]      tst_cnt_r;
	logic [IRQ_W-1:0] irq_set;
	logic [IRQ_W-1:0] irq_clr;
	wire tst_act  = ctrl_r.irq_out_test;
	wire tst_end  = tst_act & (tst_cnt_r == 12'(TEST_CYC - 1));
	wire casc_fal = casc_prev_r & ~CASCADE_IRQ_IN_N;
	wire ew_rise  = (ew_st_r == EW_IDLE) & (ew_st_nxt == EW_LEAD);
	assign irq_set = {uv_hit, ov_hit, wd_ev_r, ew_rise, casc_fal};
	assign irq_clr = (wr & hit_irq) ? PWDATA_IN[IRQ_W-1:0] : '0;
	assign IRQ_N_OUT    = 1'b0;
	assign IRQ_N_OE_OUT = |(irq_r & ~mask_r) | tst_act;
	assign status_w = {23'h00_0000, |(REG_UV_IN & pg_part),
		|(REG_OV_IN & pg_part), EARLY_WARN_OUT, pg_hi_r, released,
		standby, REG_TWO_ENABLE_PIN_IN, REG_TWO_VOLT_SEL_PIN_IN,
		CASCADE_IRQ_IN_N};

	// Set wins over a simultaneous write-one clear
	always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
		if (!rst_n) begin
			irq_r       <= '0;
			casc_prev_r <= 1'b1;
			tst_cnt_r   <= 12'h000;
		end else begin
			irq_r       <= (irq_r & ~irq_clr) | irq_set;
			casc_prev_r <= CASCADE_IRQ_IN_N;
			tst_cnt_r   <= tst_act & ~tst_end ? tst_cnt_r + 12'h001
				: 12'h000;
		end
	end

	// Software writes; defaults come from fuse image constants
	always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r   <= CTRL_RST;
			cfg_r    <= CFG_RST;
			codes_r  <= CODES_RST;
			pg_sel_r <= '0;
			mask_r   <= MASK_RST;
		end else begin
			if (wr & hit_ctl) ctrl_r <= pcl_ctrl_t'(PWDATA_IN[9:0]);
			else if (tst_end) ctrl_r.irq_out_test <= 1'b0;
			if (wr & hit_cfg) cfg_r <= pcl_cfg_t'(PWDATA_IN[22:0]);
			if (wr & hit_cod) codes_r <= PWDATA_IN[7:0];
			if (wr & hit_sel) pg_sel_r <= PWDATA_IN[N_REG-1:0];
			if (wr & hit_msk) mask_r <= PWDATA_IN[IRQ_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks

	default clocking @(posedge CLK_SYS_IN); endclocking
	default disable iff (!rst_n);

	property p_rst_off;
		MODE_OFF_IN |=> HOST_RESET_N_OE_OUT;
	endproperty
	a_rst_off: assert property (p_rst_off)
		else $error("host reset not held in off mode");
	property p_rst_rel;
		(rst_st_r == RST_HELD) && rel_pt && !MODE_OFF_IN
			|=> !HOST_RESET_N_OE_OUT;
	endproperty
	a_rst_rel: assert property (p_rst_rel)
		else $error("host reset not released at its slot");
	property p_tst;
		$rose(tst_act) |-> IRQ_N_OE_OUT [*8];
	endproperty
	a_tst: assert property (p_tst)
		else $error("irq test pulse not driven");
	property p_tst_len;
		$fell(tst_act) && !$past(wr) |-> $past(tst_cnt_r) == 12'(TEST_CYC - 1);
	endproperty
	a_tst_len: assert property (p_tst_len)
		else $error("irq test pulse length wrong");
	property p_casc;
		$fell(CASCADE_IRQ_IN_N) |=> irq_r[IRQ_CASC];
	endproperty
	a_casc: assert property (p_casc)
		else $error("cascade edge not latched");
	property p_wd_gate;
		WDOG_EVENT_OUT |-> $past(wd_mon);
	endproperty
	a_wd_gate: assert property (p_wd_gate)
		else $error("watchdog event while gated");
	property p_ew_off;
		MODE_OFF_IN |=> !EARLY_WARN_OUT;
	endproperty
	a_ew_off: assert property (p_ew_off)
		else $error("early warning high in off mode");
	property p_ew_irq;
		$rose(EARLY_WARN_OUT) |-> irq_r[IRQ_EARLY_WARN_OUT];
	endproperty
	a_ew_irq: assert property (p_ew_irq)
		else $error("early warning irq not set");
	property p_pg_hold;
		cfg_r.power_good_mode_sel && !released |=> POWER_GOOD_OE_OUT;
	endproperty
	a_pg_hold: assert property (p_pg_hold)
		else $error("power good released before reset release");
	property p_r2_pin;
		ctrl_r.reg_two_pin_control_en && !REG_TWO_ENABLE_PIN_IN
			|-> !REG_TWO_EN_OUT;
	endproperty
	a_r2_pin: assert property (p_r2_pin)
		else $error("regulator two enabled with pin low");

endmodule // pcl_top

// *** pkg/pcl_pkg.sv ***
package pcl_pkg;
	// Clock and timing
	localparam int unsigned CLK_MHZ       = 40;
	localparam int unsigned TEST_PULSE_US = 100;
	localparam int unsigned DBNC_US       = 10;
	localparam int unsigned EW_T0_US      = 100;
	localparam int unsigned EW_T1_US      = 5_000;
	localparam int unsigned EW_T2_US      = 20_000;
	localparam int unsigned EW_T3_US      = 50_000;
	localparam int unsigned TEST_CYC      = TEST_PULSE_US * CLK_MHZ;
	localparam int unsigned DBNC_CYC      = DBNC_US * CLK_MHZ;
	localparam int unsigned EW_T0_CYC     = EW_T0_US * CLK_MHZ;
	localparam int unsigned EW_T1_CYC     = EW_T1_US * CLK_MHZ;
	localparam int unsigned EW_T2_CYC     = EW_T2_US * CLK_MHZ;
	localparam int unsigned EW_T3_CYC     = EW_T3_US * CLK_MHZ;
	// Register byte offsets
	localparam logic [11:0] OFS_CTRL   = 12'h000;
	localparam logic [11:0] OFS_CFG    = 12'h004;
	localparam logic [11:0] OFS_CODES  = 12'h008;
	localparam logic [11:0] OFS_PG_SEL = 12'h00C;
	localparam logic [11:0] OFS_IRQ    = 12'h010;
	localparam logic [11:0] OFS_MASK   = 12'h014;
	localparam logic [11:0] OFS_STAT   = 12'h018;
	// Interrupt latch positions
	localparam int unsigned IRQ_W     = 5;
	localparam int unsigned IRQ_CASC  = 0;
	localparam int unsigned IRQ_EARLY_WARN_OUT = 1;
	localparam int unsigned IRQ_WDOG  = 2;
	localparam int unsigned IRQ_OV    = 3;
	localparam int unsigned IRQ_UV    = 4;
	// Regulator two output codes for the pin-selected voltages
	localparam logic [3:0] CODE_3V3 = 4'hF;
	localparam logic [3:0] CODE_1V8 = 4'h8;
	// Power-up defaults of fuse-backed bits
	localparam logic [7:0] RST_SLOT_DEF   = 8'h0_2;
	localparam logic [7:0] PG_SLOT_DEF    = 8'h0_0;
	localparam logic       WD_SLEEP_DEF   = 1'b0;
	localparam logic       VPIN_EN_DEF    = 1'b0;
	localparam logic       PINCTL_EN_DEF  = 1'b0;
	localparam logic       PG_GPO_DEF     = (PG_SLOT_DEF != 8'h0_0);
	localparam logic [7:0] CODES_RST      = 8'h0_F;
	localparam logic [4:0] MASK_RST       = 5'h1_F;

	// Software control bits
	typedef struct packed {
		logic reg_two_sleep_on;
		logic reg_two_run_on;
		logic reg_two_pin_control_en;
		logic reg_two_volt_pin_en;
		logic pg_pin_sleep_level;
		logic pg_pin_run_level;
		logic input_overvolt_shutdown_en;
		logic wdog_in_sleep_active;
		logic irq_out_test;
		logic standby_polarity_invert;
	} pcl_ctrl_t;

	// Fuse image, writable for bring-up
	typedef struct packed {
		logic       power_good_mode_sel;
		logic       wdog_in_hard_sel;
		logic       wdog_in_edge_sel;
		logic [1:0] early_warn_lead_time;
		logic [1:0] sequence_time_base;
		logic [7:0] pg_pin_power_up_slot;
		logic [7:0] host_reset_release_slot;
	} pcl_cfg_t;

	localparam pcl_ctrl_t CTRL_RST = '{1'b1, 1'b1, PINCTL_EN_DEF,
		VPIN_EN_DEF, PG_GPO_DEF, PG_GPO_DEF, 1'b0, WD_SLEEP_DEF,
		1'b0, 1'b0};
	localparam pcl_cfg_t CFG_RST = '{1'b0, 1'b0, 1'b0, 2'b00, 2'b00,
		PG_SLOT_DEF, RST_SLOT_DEF};

	// Host reset and early warning state machines
	typedef enum logic [1:0] {
		RST_HELD = 2'b01,
		RST_FREE = 2'b10
	} pcl_rst_st_t;
	typedef enum logic [2:0] {
		EW_IDLE = 3'b001,
		EW_LEAD = 3'b010,
		EW_DONE = 3'b100
	} pcl_ew_st_t;
endpackage

// *** testbench/pcl_host_model.sv ***
`timescale 1ns/1ps
// Host processor side of the control pins
module pcl_host_model (
	input  wire logic clk_in,
	input  wire logic irq_oe_in,
	input  wire logic rst_oe_in,
	output logic      irq_pin_n_out,
	output logic      rst_pin_n_out,
	output logic      wdog_out,
	output logic      casc_n_out
);
	////////////////////////////////////////
	// Open-drain lines read high through the pull-ups when released
	assign irq_pin_n_out = irq_oe_in ? 1'b0 : 1'b1;
	assign rst_pin_n_out = rst_oe_in ? 1'b0 : 1'b1;
	// Idle levels: watchdog pulled down, cascade pulled up
	initial begin
		wdog_out   = 1'b0;
		casc_n_out = 1'b1;
	end
	// Watchdog pulse: high then low, each for len cycles
	task automatic wdog_pulse(input int len);
		@(posedge clk_in) wdog_out <= 1'b1;
		repeat (len) @(posedge clk_in);
		wdog_out <= 1'b0;
		repeat (len) @(posedge clk_in);
	endtask
	// Companion irq line level, then time to be seen
	task automatic casc_set(input logic v);
		@(posedge clk_in) casc_n_out <= v;
		repeat (4) @(posedge clk_in);
	endtask
endmodule // pcl_host_model

// *** testbench/pmic_control_pin_logic_tb_top.sv ***
`timescale 1ns/1ps
module pmic_control_pin_logic_tb_top;
	import pcl_pkg::*;
	localparam int unsigned EW1 = 50; // Short lead count for sim
	logic        clk, rstn, psel, pen, pwr, off, pwrup, syson, pdslot;
	logic        ft, fcm, thsd, ovlo, stby, vsel, ldoen, last_hard;
	logic        pready, perr, err, irq_n, rst_n, wd, casc_n, st;
	logic        rst_oe, rfree, irq_oe, wd_ev, wd_hard, ew, go, pg_oe, r2en;
	logic        pf;
	logic [10:0] gd, ren, ov, uv;
	logic [11:0] paddr;
	logic [31:0] pwd, prd, rd;
	logic [7:0]  slot;
	logic [3:0]  code;
	int          n_errors, tests_run, cyc, t_go, n_wd, n_pf;
	////////////////////////////////////////
	pcl_top #(.EW1_CYC(EW1), .EW2_CYC(80), .EW3_CYC(120)) u_dut (
		.CLK_SYS_IN(clk), .RESETN_IN(rstn), .PSEL_IN(psel),
		.PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
		.PWDATA_IN(pwd), .PRDATA_OUT(prd), .PREADY_OUT(pready),
		.PSLVERR_OUT(perr), .MODE_OFF_IN(off), .MODE_PWRUP_IN(pwrup),
		.MODE_SYSON_IN(syson), .PWRUP_SLOT_IN(slot),
		.PWRDN_RESET_SLOT_IN(pdslot), .FAULT_TIMER_IN(ft),
		.FAULT_CNT_MAX_IN(fcm), .THERMAL_SD_IN(thsd), .VIN_OVLO_IN(ovlo),
		.REG_GOOD_IN(gd), .REG_ENABLED_IN(ren), .REG_OV_IN(ov),
		.REG_UV_IN(uv), .STANDBY_IN(stby), .CASCADE_IRQ_IN_N(casc_n),
		.WDOG_IN(wd), .REG_TWO_VOLT_SEL_PIN_IN(vsel),
		.REG_TWO_ENABLE_PIN_IN(ldoen), .STANDBY_STATE_OUT(st),
		.HOST_RESET_N_OUT(), .HOST_RESET_N_OE_OUT(rst_oe),
		.HOST_RESET_FREE_OUT(rfree), .IRQ_N_OUT(), .IRQ_N_OE_OUT(irq_oe),
		.WDOG_EVENT_OUT(wd_ev), .WDOG_HARD_OUT(wd_hard),
		.EARLY_WARN_OUT(ew), .POWER_DOWN_GO_OUT(go), .POWER_GOOD_OUT(),
		.POWER_GOOD_OE_OUT(pg_oe), .PG_FAULT_OUT(pf),
		.REG_TWO_CODE_OUT(code), .REG_TWO_EN_OUT(r2en));
	pcl_host_model u_host (.clk_in(clk), .irq_oe_in(irq_oe),
		.rst_oe_in(rst_oe), .irq_pin_n_out(irq_n), .rst_pin_n_out(rst_n),
		.wdog_out(wd), .casc_n_out(casc_n));
	// Free-running 40 MHz clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// One-cycle pulses are caught here, so tasks can look later
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (go === 1'b1) t_go <= cyc;
		if (pf === 1'b1) n_pf <= n_pf + 1;
		if (wd_ev === 1'b1) begin
			n_wd      <= n_wd + 1;
			last_hard <= wd_hard;
		end
	end
	////////////////////////////////////////
	task automatic chk(input logic [31:0] got, exp, input string what);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t %s: got %h exp %h", $time, what, got, exp);
		end
	endtask
	// One APB transfer; waits for pready, never assumes a count
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel  <= 1'b1;
		pen   <= 1'b0;
		pwr   <= w;
		paddr <= a;
		pwd   <= d;
		@(posedge clk) pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prd;
		err = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, e, "read value");
	endtask
	task automatic summarize();
		$display("Checks %0d, mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	////////////////////////////////////////
	task automatic t_regs();
		rchk(OFS_CTRL, 32'h0000_0300);
		rchk(OFS_CFG, 32'h0000_0002);
		rchk(OFS_CODES, 32'h0000_000F);
		rchk(OFS_MASK, 32'h0000_001F);
		rchk(12'h01C, 32'h0000_0000);
		chk(err, 1'b1, "unmapped error");
		$display("test regs done");
	endtask
	task automatic t_reset();
		off <= 1'b0; pwrup <= 1'b1; slot <= 8'h01;
		repeat (4) @(posedge clk);
		chk(rfree, 1'b0, "reset early");
		u_host.wdog_pulse(450);
		chk(n_wd, 0, "wdog masked");
		slot <= 8'h02;
		repeat (4) @(posedge clk);
		chk(rst_n, 1'b1, "reset released");
		pwrup <= 1'b0;
		syson <= 1'b1;
		repeat (4) @(posedge clk);
		chk(rst_n, 1'b1, "reset held free");
		$display("test reset done");
	endtask
	// All four pin and invert combinations
	task automatic t_standby();
		for (int i = 0; i < 4; i++) begin
			stby <= i[0];
			apb(1'b1, OFS_CTRL, 32'h0000_0300 | i[1]);
			repeat (4) @(posedge clk);
			chk(st, i[0] ^ i[1], "standby");
		end
		stby <= 1'b0;
		apb(1'b1, OFS_CTRL, 32'h0000_0300);
		$display("test standby done");
	endtask
	task automatic t_irq();
		int n;
		apb(1'b1, OFS_CTRL, 32'h0000_0302);
		n = 0;
		while (irq_n !== 1'b0 && n < 10) begin @(posedge clk); n++; end
		n = 0;
		while (irq_n === 1'b0 && n < 5000) begin @(posedge clk); n++; end
		chk(n >= 3999 && n <= 4002, 1'b1, "test pulse");
		rchk(OFS_CTRL, 32'h0000_0300);
		apb(1'b1, OFS_MASK, 32'h0000_001E);
		u_host.casc_set(1'b0);
		chk(irq_n, 1'b0, "cascade irq");
		apb(1'b0, OFS_STAT, 32'h0000_0000);
		chk(rd[0], 1'b0, "cascade level");
		u_host.casc_set(1'b1);
		apb(1'b1, OFS_IRQ, 32'h0000_0001);
		repeat (3) @(posedge clk);
		chk(irq_n, 1'b1, "irq cleared");
		apb(1'b1, OFS_MASK, 32'h0000_001F);
		u_host.casc_set(1'b0);
		chk(irq_n, 1'b1, "masked irq");
		rchk(OFS_IRQ, 32'h0000_0001);
		u_host.casc_set(1'b1);
		apb(1'b1, OFS_IRQ, 32'h0000_0001);
		$display("test irq done");
	endtask
	// Rising edge select, debounce, mode and standby gating
	task automatic t_wdog();
		apb(1'b1, OFS_CFG, 32'h0010_0002);
		u_host.wdog_pulse(300);
		chk(n_wd, 0, "short pulse");
		u_host.wdog_pulse(450);
		chk(n_wd, 1, "edge event");
		chk(last_hard, 1'b0, "soft");
		apb(1'b1, OFS_CFG, 32'h0030_0002);
		u_host.wdog_pulse(450);
		chk(last_hard, 1'b1, "hard");
		stby <= 1'b1;
		u_host.wdog_pulse(450);
		chk(n_wd, 2, "sleep ignored");
		apb(1'b1, OFS_CTRL, 32'h0000_0304);
		u_host.wdog_pulse(450);
		chk(n_wd, 3, "sleep active");
		stby <= 1'b0;
		apb(1'b1, OFS_CTRL, 32'h0000_0300);
		$display("test wdog done");
	endtask
	task automatic t_reg2();
		chk(pg_oe, 1'b1, "gpo low");
		apb(1'b1, OFS_CTRL, 32'h0000_0350);
		vsel <= 1'b0;
		repeat (4) @(posedge clk);
		chk(code, CODE_3V3, "pin low code");
		chk(pg_oe, 1'b0, "gpo high");
		vsel <= 1'b1;
		repeat (4) @(posedge clk);
		chk(code, CODE_1V8, "pin high code");
		apb(1'b1, OFS_CODES, 32'h0000_005A);
		apb(1'b1, OFS_CTRL, 32'h0000_0380);
		@(posedge clk);
		chk(code, 4'hA, "run code");
		stby <= 1'b1;
		repeat (4) @(posedge clk);
		chk(code, 4'h5, "sleep code");
		stby  <= 1'b0;
		ldoen <= 1'b0;
		repeat (4) @(posedge clk);
		chk(r2en, 1'b0, "pin off");
		ldoen <= 1'b1;
		apb(1'b0, OFS_STAT, 32'h0000_0000);
		chk(rd[2:1], 2'b11, "pin levels");
		chk(r2en, 1'b1, "pin on");
		apb(1'b1, OFS_CTRL, 32'h0000_0280);
		@(posedge clk);
		chk(r2en, 1'b0, "run bit off");
		$display("test reg two done");
	endtask
	// Each fault cause, lead time once, then off mode
	task automatic t_early_warn_out();
		int n, t0;
		apb(1'b1, OFS_CFG, 32'h0004_0002);
		apb(1'b1, OFS_MASK, 32'h0000_001D);
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, OFS_CTRL, (i == 3) ? 32'h0000_0308 : 32'h0000_0300);
			{ft, fcm, thsd, ovlo} <= (i < 4) ? 4'b1000 >> i : 4'b0001;
			n = 0;
			while (ew !== 1'b1 && n < 20) begin @(posedge clk); n++; end
			chk(ew, i < 4, "warn raised");
			if (i == 0) begin
				t0 = cyc;
				t_go = 0;
				repeat (EW1 + 10) @(posedge clk);
				chk(t_go - t0 >= 48 && t_go - t0 <= 53, 1'b1, "lead");
				chk(irq_n, 1'b0, "warn irq");
			end
			{ft, fcm, thsd, ovlo} <= 4'b0000;
			off <= 1'b1;
			repeat (4) @(posedge clk);
			chk(ew, 1'b0, "off low");
			chk(rst_n, 1'b0, "reset asserted");
			off <= 1'b0;
		end
		$display("test warn done");
	endtask
	// Good mode: second power-up, AND of monitors, sticky latch
	task automatic t_pg();
		apb(1'b1, OFS_PG_SEL, 32'h0000_0003);
		apb(1'b1, OFS_CFG, 32'h0040_0002);
		syson <= 1'b0;
		pwrup <= 1'b1;
		slot  <= 8'h01;
		repeat (4) @(posedge clk);
		chk(pg_oe, 1'b1, "held before release");
		gd   <= 11'h7FE;
		slot <= 8'h02;
		repeat (4) @(posedge clk);
		chk(rfree, 1'b1, "released again");
		chk(n_pf, 1, "bad at release");
		chk(pg_oe, 1'b1, "kept low");
		gd    <= '1;
		pwrup <= 1'b0;
		syson <= 1'b1;
		repeat (4) @(posedge clk);
		chk(pg_oe, 1'b0, "all good");
		gd <= 11'h7FD;
		repeat (4) @(posedge clk);
		chk(pg_oe, 1'b1, "one bad");
		ren <= 11'h7FD;
		repeat (4) @(posedge clk);
		chk(pg_oe, 1'b0, "disabled dropped");
		uv <= 11'h001;
		ov <= 11'h002;
		apb(1'b0, OFS_STAT, 32'h0000_0000);
		chk(rd[8:7], 2'b10, "live uv");
		uv <= '0;
		ov <= '0;
		apb(1'b0, OFS_STAT, 32'h0000_0000);
		chk(rd[8:7], 2'b00, "live cleared");
		apb(1'b0, OFS_IRQ, 32'h0000_0000);
		chk(rd[4:3], 2'b10, "uv latched");
		pdslot <= 1'b1;
		repeat (4) @(posedge clk);
		chk(rst_n, 1'b0, "power-down slot");
		$display("test power good done");
	endtask
	////////////////////////////////////////
	initial begin
		{psel, pen, pwr, pdslot, ft, fcm, thsd, ovlo} = '0;
		{stby, vsel, ldoen, pwrup, syson, rstn, ov, uv} = '0;
		gd = '1;
		ren = '1;
		off = 1'b1;
		paddr = '0;
		pwd = '0;
		slot = '0;
		{n_errors, tests_run, cyc, t_go, n_wd, n_pf} = '0;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		t_regs();
		t_reset();
		t_standby();
		t_irq();
		t_wdog();
		t_reg2();
		t_early_warn_out();
		t_pg();
		summarize();
	end
	// Hang guard, about four times the expected run
	initial begin
		#1_000_000;
		n_errors++;
		summarize();
	end
endmodule // pmic_control_pin_logic_tb_top
